// *** src/ddrpd_pkg.sv ***
/*
  Constants for the DDR2 refresh and power-down state tracker: command field
  positions, state codes, reset values and timing counts at the 25 MHz clock.
  Assumes the tracker samples the command pins on every rising edge.
*/
package ddrpd_pkg;

  // Clock period in ns at 25 MHz
  localparam int CLK_PERIOD_NS = 40;

  // Average refresh interval, rounded down to whole cycles (a longest time)
  localparam int T_REFI_NS  = 7800;
  localparam int REFI_CYC   = (T_REFI_NS / CLK_PERIOD_NS < 1) ? 1 : T_REFI_NS / CLK_PERIOD_NS;

  // Refresh cycle time, rounded up (a least time); plain default
  localparam int T_RFC_NS   = 200;
  localparam int RFC_CYC    = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Self-refresh exit to non-read command, rounded up; plain default
  localparam int T_XSNR_NS  = 210;
  localparam int XSNR_CYC   = (T_XSNR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Exit latencies given in clock cycles; plain defaults
  localparam int XSRD_CYC   = 200;
  localparam int XP_CYC     = 2;
  localparam int XARD_CYC   = 2;
  localparam int XARDS_CYC  = 6;

  // Write with auto-precharge to internal precharge, in cycles; plain default
  localparam int AP_CYC     = 7;

  // Widths
  localparam int CNT_W      = 8;
  localparam int ROW_W      = 13;
  localparam int ADDR_W     = 14;
  localparam int BANK_W     = 3;
  localparam int PIN_W      = 5 + BANK_W + ADDR_W;

  // Address bit positions
  localparam int AUTOPRE_BIT = 10;  // autoprecharge_bit
  localparam int PDEXIT_BIT  = 12;  // pd_exit_mode_bit

  // Pin synchroniser reset value: clock gate low, strobes high (deselect)
  localparam logic [PIN_W-1:0] PIN_RST = 22'h1e_0000;

  // Tracked power states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ACTIVE   = 3'b001,
    ST_PRE_PD   = 3'b010,
    ST_ACT_PD   = 3'b011,
    ST_SELF_REF = 3'b100
  } ddrpd_state_e;

endpackage : ddrpd_pkg

// *** src/ddrpd_sync.sv ***
/*
  Two-flop synchroniser for a vector of pin inputs.
  Assumes each bit is a level that is stable for more than one clock period.
*/
`timescale 1ns/1ps
module ddrpd_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule // ddrpd_sync

// *** src/ddrpd_core.sv ***
/*
  DDR2 device-side refresh and power-down tracker: decodes commands from the
  pins, keeps the internal refresh row counter, the open-bank map, the
  auto-precharge closure, the power state, DLL enable and exit latencies.
  Assumes the controller keeps its own spacing rules; pins are asynchronous.
*/
// Notes on behaviour
// [RULE_01] Controller may address another bank during auto-precharge without data clash.
// [RULE_02] Controller spaces commands after write with auto-precharge per table.
// [RULE_03] Controller spaces commands after read with auto-precharge per table.
// [RULE_04] Every row must be refreshed within any rolling 64 ms.
// [RULE_05] CS, RAS, CAS low and WE high with clock gate high is auto-refresh.
// [RULE_06] Refresh rows come from the internal counter; address bus ignored.
// [RULE_07] Controller precharges all banks for precharge time before refresh.
// [RULE_08] Refresh leaves banks idle; refresh cycle time must pass afterwards.
// [RULE_09] At most eight refreshes postponed; gap under nine refresh intervals.
// [RULE_10] Termination off and banks idle before self-refresh entry.
// [RULE_11] Refresh decode with clock gate low enters self-refresh; only gate matters.
// [RULE_12] Clock may stop one cycle after self-refresh entry; stable before exit.
// [RULE_13] Clock gate high and NOP or deselect throughout self-refresh exit.
// [RULE_14] Read waits read exit delay; other commands wait non-read exit delay.
// [RULE_15] Clock gate low with NOP or deselect enters power-down.
// [RULE_16] Open row gives active power-down, else precharge; mode bit picks exit.
// [RULE_17] DLL off in precharge and slow-exit power-down, on in fast-exit.
// [RULE_18] Controller ends power-down within nine refresh intervals, clock stable.
// [RULE_19] Clock gate high with NOP exits power-down; exit latency then applies.
// [RULE_20] Active power-down after read only after read latency plus half burst.
// [RULE_21] Active power-down after write waits write latency, half burst, write-to-read delay.
// [RULE_22] Power-down after write with auto-precharge waits for internal precharge.
// [RULE_23] Autoprecharge bit high with read or write closes the bank afterwards.
// [RULE_24] State tracked from previous and current clock gate values.
`timescale 1ns/1ps
module ddrpd_core #(
  parameter int NUM_BANKS = 8,
  parameter int REFI_CYC  = ddrpd_pkg::REFI_CYC,
  parameter int RFC_CYC   = ddrpd_pkg::RFC_CYC,
  parameter int XSNR_CYC  = ddrpd_pkg::XSNR_CYC,
  parameter int XSRD_CYC  = ddrpd_pkg::XSRD_CYC,
  parameter int XP_CYC    = ddrpd_pkg::XP_CYC,
  parameter int XARD_CYC  = ddrpd_pkg::XARD_CYC,
  parameter int XARDS_CYC = ddrpd_pkg::XARDS_CYC,
  parameter int AP_CYC    = ddrpd_pkg::AP_CYC
) (
  input  wire logic                              i_ref_clk,
  input  wire logic                              i_rst,
  input  wire logic                              i_cke,
  input  wire logic                              i_cs_n,
  input  wire logic                              i_ras_n,
  input  wire logic                              i_cas_n,
  input  wire logic                              i_we_n,
  input  wire logic [ddrpd_pkg::BANK_W-1:0]      i_ba,
  input  wire logic [ddrpd_pkg::ADDR_W-1:0]      i_addr,
  output logic      [2:0]                        o_state,
  output logic                                   o_dll_en,
  output logic      [NUM_BANKS-1:0]              o_banks_open,
  output logic      [ddrpd_pkg::ROW_W-1:0]       o_refresh_row,
  output logic                                   o_refresh_busy,
  output logic                                   o_cmd_ready,
  output logic                                   o_read_ready,
  output logic                                   o_slow_exit,
  output logic                                   o_ap_pending
);

  localparam int CW = ddrpd_pkg::CNT_W;

  // One-hot bank select, used for activate, precharge and auto-precharge
  function automatic logic [NUM_BANKS-1:0] bank_mask(input logic [ddrpd_pkg::BANK_W-1:0] ba);
    bank_mask = '0;
    bank_mask[ba] = 1'b1;
  endfunction

  // Pins are sampled asynchronously, so all go through two flops
  logic [ddrpd_pkg::PIN_W-1:0] pins_s;
  ddrpd_sync #(
    .W       (ddrpd_pkg::PIN_W),
    .RST_VAL (ddrpd_pkg::PIN_RST)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   ({i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_addr}),
    .o_sync    (pins_s)
  );

  wire                          cke_cur = pins_s[21];
  wire                          cs_n    = pins_s[20];
  wire                          ras_n   = pins_s[19];
  wire                          cas_n   = pins_s[18];
  wire                          we_n    = pins_s[17];
  wire [ddrpd_pkg::BANK_W-1:0]  ba      = pins_s[16:14];
  wire [ddrpd_pkg::ADDR_W-1:0]  addr    = pins_s[13:0];

  ddrpd_pkg::ddrpd_state_e state_q, state_d;
  logic                    cke_prev_q;
  logic [NUM_BANKS-1:0]    open_q, open_d;
  logic [ddrpd_pkg::ROW_W-1:0] row_q;
  logic [CW-1:0]           rfc_q, rfc_d, exit_q, exit_d, rdx_q, rdx_d;
  logic [CW-1:0]           ap_q, ap_d, srt_q;
  logic [ddrpd_pkg::BANK_W-1:0] ap_bank_q;
  logic                    slow_q;

  // Command decode on the registered clock gate pair
  wire normal   = (state_q == ddrpd_pkg::ST_IDLE) || (state_q == ddrpd_pkg::ST_ACTIVE);
  wire is_nop   = cs_n || (ras_n && cas_n && we_n);
  wire both_hi  = cke_prev_q && cke_cur;
  wire ref_code = !cs_n && !ras_n && !cas_n && we_n;
  wire cmd_ref  = normal && both_hi && ref_code;                  // see [RULE_05]
  wire cmd_sre  = normal && cke_prev_q && !cke_cur && ref_code;   // see [RULE_11]
  wire cmd_mode = normal && both_hi && !cs_n && !ras_n && !cas_n && !we_n;
  wire cmd_act  = normal && both_hi && !cs_n && !ras_n && cas_n && we_n;
  wire cmd_pre  = normal && both_hi && !cs_n && !ras_n && cas_n && !we_n;
  wire cmd_rdwr = normal && both_hi && !cs_n && ras_n && !cas_n;
  wire cmd_ap   = cmd_rdwr && addr[ddrpd_pkg::AUTOPRE_BIT];       // see [RULE_23]
  wire pd_entry = normal && cke_prev_q && !cke_cur && is_nop;      // see [RULE_15]
  wire pd_state = (state_q == ddrpd_pkg::ST_PRE_PD) || (state_q == ddrpd_pkg::ST_ACT_PD);
  wire pd_exit  = pd_state && !cke_prev_q && cke_cur && is_nop;    // see [RULE_19]
  wire sr_exit  = (state_q == ddrpd_pkg::ST_SELF_REF) && cke_cur;  // see [RULE_11]
  wire sr_tick  = (state_q == ddrpd_pkg::ST_SELF_REF) && (srt_q == CW'(REFI_CYC - 1));
  wire ap_done  = (ap_q == CW'(1));
  wire [NUM_BANKS-1:0] pre_mask = addr[ddrpd_pkg::AUTOPRE_BIT] ? '1 : bank_mask(ba);

  // Open-bank map; a second auto-precharge closes the older bank at once
  always_comb begin
    open_d = open_q;
    ap_d   = (ap_q != '0) ? ap_q - CW'(1) : ap_q;
    if (ap_done) begin
      open_d = open_d & ~bank_mask(ap_bank_q);                    // see [RULE_23]
    end
    if (cmd_ap) begin
      if (ap_q > CW'(1)) begin
        open_d = open_d & ~bank_mask(ap_bank_q);
      end
      ap_d = CW'(AP_CYC);                                         // see [RULE_22]
    end
    if (cmd_act) begin
      open_d = open_d | bank_mask(ba);
    end
    if (cmd_pre) begin
      open_d = open_d & ~pre_mask;
    end
    if (cmd_ref) begin
      open_d = '0;                                                // see [RULE_08]
    end
  end

  // Power state from previous and current clock gate values
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ddrpd_pkg::ST_IDLE,
      ddrpd_pkg::ST_ACTIVE: begin
        if (cmd_sre) begin
          state_d = ddrpd_pkg::ST_SELF_REF;                       // see [RULE_24]
        end else if (pd_entry) begin
          state_d = (open_q != '0) ? ddrpd_pkg::ST_ACT_PD         // see [RULE_16]
                                   : ddrpd_pkg::ST_PRE_PD;
        end else begin
          state_d = (open_d != '0) ? ddrpd_pkg::ST_ACTIVE : ddrpd_pkg::ST_IDLE;
        end
      end
      ddrpd_pkg::ST_PRE_PD,
      ddrpd_pkg::ST_ACT_PD: begin
        if (pd_exit) begin
          state_d = (open_d != '0) ? ddrpd_pkg::ST_ACTIVE : ddrpd_pkg::ST_IDLE;
        end
      end
      ddrpd_pkg::ST_SELF_REF: begin
        if (sr_exit) begin
          state_d = ddrpd_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = ddrpd_pkg::ST_IDLE;
      end
    endcase
  end

  // Exit latency and refresh busy counters
  wire [CW-1:0] pd_lat = (state_q == ddrpd_pkg::ST_PRE_PD) ? CW'(XP_CYC) :
                         (slow_q ? CW'(XARDS_CYC) : CW'(XARD_CYC));
  assign rfc_d  = cmd_ref ? CW'(RFC_CYC) : ((rfc_q != '0) ? rfc_q - CW'(1) : rfc_q);
  assign exit_d = sr_exit ? CW'(XSNR_CYC) :                        // see [RULE_14]
                  pd_exit ? pd_lat :                               // see [RULE_19]
                  ((exit_q != '0) ? exit_q - CW'(1) : exit_q);
  assign rdx_d  = sr_exit ? CW'(XSRD_CYC) :
                  pd_exit ? pd_lat :
                  ((rdx_q != '0) ? rdx_q - CW'(1) : rdx_q);

  // DLL stays on only in normal states and fast-exit active power-down
  wire dll_d = (state_d == ddrpd_pkg::ST_IDLE) || (state_d == ddrpd_pkg::ST_ACTIVE) ||
               ((state_d == ddrpd_pkg::ST_ACT_PD) && !slow_q);      // see [RULE_17]

  // State, counters and registered outputs
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_q    <= ddrpd_pkg::ST_IDLE;
      cke_prev_q <= 1'b0;
      open_q     <= '0;
      row_q      <= '0;
      rfc_q      <= '0;
      exit_q     <= '0;
      rdx_q      <= '0;
      ap_q       <= '0;
      ap_bank_q  <= '0;
      srt_q      <= '0;
      slow_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      cke_prev_q <= cke_cur;
      open_q     <= open_d;
      rfc_q      <= rfc_d;
      exit_q     <= exit_d;
      rdx_q      <= rdx_d;
      ap_q       <= ap_d;
      if (cmd_ap) begin
        ap_bank_q <= ba;
      end
      // Address bus never feeds the row counter
      if (cmd_ref || sr_tick) begin
        row_q <= row_q + ddrpd_pkg::ROW_W'(1);                     // see [RULE_06]
      end
      // Internal self-refresh timer restarts on each entry
      srt_q <= (state_q != ddrpd_pkg::ST_SELF_REF || sr_tick) ? '0 : srt_q + CW'(1);
      if (cmd_mode && ba == '0) begin
        slow_q <= addr[ddrpd_pkg::PDEXIT_BIT];                     // see [RULE_16]
      end
    end
  end

  // Output flops follow the next-state values so they align with state_q
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_dll_en       <= 1'b1;
      o_refresh_busy <= 1'b0;
      o_cmd_ready    <= 1'b1;
      o_read_ready   <= 1'b1;
      o_ap_pending   <= 1'b0;
    end else begin
      o_dll_en       <= dll_d;
      o_refresh_busy <= (rfc_d != '0);
      o_cmd_ready    <= (exit_d == '0) && (rfc_d == '0);
      o_read_ready   <= (rdx_d == '0) && (rfc_d == '0);
      o_ap_pending   <= (ap_d != '0);
    end
  end

  assign o_state       = state_q;
  assign o_banks_open  = open_q;
  assign o_refresh_row = row_q;
  assign o_slow_exit   = slow_q;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  ref_row_step_a: assert property (cmd_ref |=> row_q == $past(row_q) + 1'b1) // see [RULE_06]
    else $error("refresh did not advance internal row");
  ref_busy_a: assert property (cmd_ref |=> o_refresh_busy && open_q == '0) // see [RULE_08]
    else $error("refresh busy or idle banks missing");
  sr_enter_a: assert property (cmd_sre |=> state_q == ddrpd_pkg::ST_SELF_REF) // see [RULE_11]
    else $error("self-refresh entry not taken");
  sr_hold_a: assert property ((state_q == ddrpd_pkg::ST_SELF_REF && !cke_cur) // see [RULE_11]
    |=> state_q == ddrpd_pkg::ST_SELF_REF)
    else $error("left self-refresh with clock gate low");
  sr_exit_lat_a: assert property (sr_exit |=> !o_cmd_ready && !o_read_ready [*2]) // see [RULE_14]
    else $error("self-refresh exit latency skipped");
  pd_kind_a: assert property (pd_entry |=> state_q == ((($past(open_q)) != '0) // see [RULE_16]
    ? ddrpd_pkg::ST_ACT_PD : ddrpd_pkg::ST_PRE_PD))
    else $error("wrong power-down kind");
  dll_mode_a: assert property ((state_q == ddrpd_pkg::ST_PRE_PD || // see [RULE_17]
    (state_q == ddrpd_pkg::ST_ACT_PD && slow_q)) |-> !o_dll_en)
    else $error("DLL left on in low-power state");
  pd_exit_lat_a: assert property (pd_exit |=> !o_cmd_ready // see [RULE_19]
    ##1 (XP_CYC > 1 ? !o_cmd_ready : 1'b1))
    else $error("power-down exit latency skipped");
  ap_close_a: assert property (cmd_ap |=> o_ap_pending && open_q[$past(ba)] // see [RULE_23]
    ##[0:7] !open_q[ap_bank_q])
    else $error("auto-precharge did not close bank");

endmodule // ddrpd_core

// *** tb/ddrpd_ctrl_model.sv ***
/*
  Behavioural DDR2 controller that drives the tracker's command pins.
  Assumes the bench calls its task in a legal order and keeps the spacing.
*/
`timescale 1ns/1ps
module ddrpd_ctrl_model (
  input  wire logic        i_ref_clk,
  output logic             o_cke,
  output logic             o_cs_n,
  output logic             o_ras_n,
  output logic             o_cas_n,
  output logic             o_we_n,
  output logic [2:0]       o_ba,
  output logic [13:0]      o_addr,
  output logic             o_term_en
);
  // Pins idle with the clock gate high and the device deselected
  initial begin
    {o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n} = 5'h1f;
    o_ba = 3'h0;
    o_addr = 14'h0000;
    o_term_en = 1'b0; // Termination stays off, so self-refresh entry is safe
  end

  // One command for one cycle, then deselect; clock gate keeps its level.
  // The address is flipped on release so a stale value never looks held.
  task automatic drive(input logic cke, input logic [3:0] cmd, input logic [2:0] ba,
                       input logic [13:0] addr);
    @(posedge i_ref_clk);
    {o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n} <= {cke, cmd};
    o_ba <= ba;
    o_addr <= addr;
    @(posedge i_ref_clk);
    o_cs_n <= 1'b1; // Deselect between commands
    o_ba <= ~ba;
    o_addr <= ~addr;
  endtask
endmodule // ddrpd_ctrl_model

// *** tb/tb_top.sv ***
/*
  Self-checking bench for the refresh and power-down tracker.
  Assumes the 25 MHz clock, three edges from pins to outputs, and the
  shortened refresh interval and self-refresh read exit set below.
*/
`timescale 1ns/1ps
module tb_top;
  localparam logic [3:0] C_NOP = 4'h7;
  localparam logic [3:0] C_REF = 4'h1;
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_WRITE = 4'h4;
  localparam logic [3:0] C_MODE = 4'h0;
  localparam logic [3:0] C_READ = 4'h5;
  logic        i_ref_clk;
  logic        i_rst;
  logic        cke, cs_n, ras_n, cas_n, we_n, dll_en, busy, cmd_rdy, rd_rdy, slow, ap;
  logic [2:0]  ba;
  logic [2:0]  state;
  logic [13:0] addr;
  logic [7:0]  banks;
  logic [12:0] row;
  logic [12:0] r0;
  int          failures, samples_checked, nc, nr;

  ddrpd_core #(.REFI_CYC(8), .XSRD_CYC(10)) i_ddrpd_core (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cke(cke), .i_cs_n(cs_n), .i_ras_n(ras_n),
    .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_addr(addr), .o_state(state),
    .o_dll_en(dll_en), .o_banks_open(banks), .o_refresh_row(row), .o_refresh_busy(busy),
    .o_cmd_ready(cmd_rdy), .o_read_ready(rd_rdy), .o_slow_exit(slow), .o_ap_pending(ap));

  ddrpd_ctrl_model i_ddrpd_ctrl_model (
    .i_ref_clk(i_ref_clk), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
    .o_we_n(we_n), .o_ba(ba), .o_addr(addr), .o_term_en());

  // Free-running 40 ns clock
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  // Sample just after an edge so its updates have landed
  task automatic settle(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_len(input string name, input int exp, input int got);
    samples_checked++;
    if (got != exp) begin
      failures++;
      $display("BAD %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  // Counts the cycles that each ready flag stays low after an exit.
  // Both are counted in one pass because they drop together.
  task automatic exit_len(output int n_cmd, output int n_rd);
    int k;
    n_cmd = 0;
    n_rd = 0;
    for (k = 0; k < 8 && cmd_rdy === 1'b1; k++)
      settle(1);
    if (k == 8) begin
      failures++;
      finish_test();
    end
    for (k = 0; k < 300 && (cmd_rdy !== 1'b1 || rd_rdy !== 1'b1); k++) begin
      n_cmd += int'(cmd_rdy !== 1'b1);
      n_rd += int'(rd_rdy !== 1'b1);
      settle(1);
    end
    if (k == 300) begin
      failures++;
      finish_test();
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence: reset, refresh, power-down kinds, auto-precharge, self-refresh
  initial begin
    i_rst = 1'b1;
    failures = 0;
    samples_checked = 0;
    repeat (8) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    settle(3);
    chk("reset outputs", {3'h0, 1'h1, 8'h00, 13'h0000, 5'h0c},
        {state, dll_en, banks, row, busy, cmd_rdy, rd_rdy, slow, ap});
    i_ddrpd_ctrl_model.drive(1'b1, C_REF, 3'h5, 14'h2aaa);
    settle(3);
    chk("refresh start", {13'h0001, 2'h2}, {row, busy, cmd_rdy});
    settle(6); // Refresh cycle time passes before the next refresh
    chk("refresh done", {8'h00, 2'h1}, {banks, busy, cmd_rdy});
    i_ddrpd_ctrl_model.drive(1'b1, C_REF, 3'h2, 14'h1555);
    settle(3);
    chk("second refresh row", 13'h0002, row);
    settle(6);
    i_ddrpd_ctrl_model.drive(1'b1, C_ACT, 3'h2, 14'h0123);
    settle(3);
    chk("activate", {8'h04, ddrpd_pkg::ST_ACTIVE}, {banks, state});
    // Fast then slow exit from active power-down
    i_ddrpd_ctrl_model.drive(1'b0, C_NOP, 3'h0, 14'h0000);
    settle(4);
    chk("fast apd", {ddrpd_pkg::ST_ACT_PD, 1'h1}, {state, dll_en});
    i_ddrpd_ctrl_model.drive(1'b1, C_NOP, 3'h0, 14'h0000); // Ended well inside
    exit_len(nc, nr);
    chk_len("fast exit", 2, nc);
    chk("after fast exit", ddrpd_pkg::ST_ACTIVE, state);
    i_ddrpd_ctrl_model.drive(1'b1, C_MODE, 3'h0, 14'h1000);
    i_ddrpd_ctrl_model.drive(1'b1, C_MODE, 3'h1, 14'h0000); // Other register leaves bit alone
    settle(3);
    chk("slow exit bit", 1'h1, slow);
    // Plain write keeps the row open; power-down waits until its burst is over
    i_ddrpd_ctrl_model.drive(1'b1, C_WRITE, 3'h2, 14'h0000);
    settle(3);
    chk("plain write", {8'h04, 1'h0}, {banks, ap});
    i_ddrpd_ctrl_model.drive(1'b0, C_NOP, 3'h0, 14'h0000); // Write done
    settle(4);
    chk("slow apd", {ddrpd_pkg::ST_ACT_PD, 1'h0}, {state, dll_en});
    i_ddrpd_ctrl_model.drive(1'b1, C_NOP, 3'h0, 14'h0000);
    exit_len(nc, nr);
    chk_len("slow exit", 6, nc);
    // Write with auto-precharge closes its bank; a single-bank precharge spares it
    i_ddrpd_ctrl_model.drive(1'b1, C_WRITE, 3'h2, 14'h0400);
    i_ddrpd_ctrl_model.drive(1'b1, C_PRE, 3'h5, 14'h0000); // Other bank
    settle(3);
    chk("ap pending", {8'h04, 1'h1}, {banks, ap});
    settle(7); // Internal precharge done before power-down
    chk("ap closed", {8'h00, 1'h0}, {banks, ap});
    i_ddrpd_ctrl_model.drive(1'b0, C_NOP, 3'h0, 14'h0000);
    settle(4);
    chk("precharge pd", {ddrpd_pkg::ST_PRE_PD, 1'h0}, {state, dll_en});
    i_ddrpd_ctrl_model.drive(1'b1, C_NOP, 3'h0, 14'h0000);
    exit_len(nc, nr);
    chk_len("precharge pd exit", 2, nc);
    // Concurrent auto-precharge: bank 3 opens while bank 6 closes itself
    i_ddrpd_ctrl_model.drive(1'b1, C_ACT, 3'h6, 14'h0042);
    i_ddrpd_ctrl_model.drive(1'b1, C_READ, 3'h6, 14'h0400);
    i_ddrpd_ctrl_model.drive(1'b1, C_ACT, 3'h3, 14'h0011);
    settle(3);
    chk("concurrent ap", {8'h48, 1'h1}, {banks, ap});
    settle(6);
    chk("other bank kept", {8'h08, 1'h0}, {banks, ap});
    i_ddrpd_ctrl_model.drive(1'b0, C_NOP, 3'h0, 14'h0000); // Read burst over
    settle(4);
    chk("apd after read", ddrpd_pkg::ST_ACT_PD, state);
    i_ddrpd_ctrl_model.drive(1'b1, C_NOP, 3'h0, 14'h0000);
    exit_len(nc, nr);
    chk_len("read apd exit", 6, nc);
    // Precharge all banks, then self-refresh
    i_ddrpd_ctrl_model.drive(1'b1, C_PRE, 3'h3, 14'h0400); // Banks idle first
    settle(5);
    chk("precharge all", 8'h00, banks);
    i_ddrpd_ctrl_model.drive(1'b0, C_REF, 3'h0, 14'h0000);
    settle(4);
    chk("self refresh", {ddrpd_pkg::ST_SELF_REF, 1'h0}, {state, dll_en});
    r0 = row;
    i_ddrpd_ctrl_model.drive(1'b0, C_ACT, 3'h1, 14'h0077); // Ignored, clock gate low
    settle(14);
    chk("self refresh rows", {r0 + 13'h0002, 8'h00}, {row, banks});
    i_ddrpd_ctrl_model.drive(1'b1, C_NOP, 3'h0, 14'h0000); // Clock never stopped
    exit_len(nc, nr);
    chk_len("self refresh exit", 6, nc);
    chk_len("self refresh read exit", 10, nr);
    chk("after self refresh", ddrpd_pkg::ST_IDLE, state);
    finish_test();
  end
endmodule // tb_top
